// >>> logic/avrx_top.sv
// Two serial word receivers with options register and host read port.
// Assumes line level detectors and the transmitter sit outside.
//
// Functional notes
// - Ten option bits load from bus lines 14..5 on the load strobe.
// - Option bit on line 5 low loops transmitter outputs into both receivers.
// - Receiver 1 filter compares word bits 9 and 10 with option bits 7, 8.
// - Receiver 2 filter compares word bits 9 and 10 with option bits 10, 11.
// - Option bit 12 selects transmitter parity: 0 odd, 1 even.
// - Option bit 13 sets transmitter data clock divide: 10 or 80.
// - Option bit 14 sets receiver sample divide: 10 or 80.
// - First half and second half map word bits to bus lines as fixed.
// - First received bit is word bit 1, numbering upward to 32.
// - Ten-stage sample registers; state valid after three equal samples.
// - A data bit must be followed by a Null within the bit time.
// - Gap Null needs three Nulls in upper and lower sample stages.
// - Bit starts must be 8 to 12 samples apart, else reject.
// - Gap timer counts Nulls each sample period; three re-enable reception.
// - Bit 32 becomes 0 for odd one-count, else 1.
// - After 32 bits, ready set if filter off or bits match.
// - Ready holds until both halves read; strobe 1 and 2 per receiver.
// - A new word before both halves are read overwrites the held one.
// - Invalid line state anywhere discards the reception.
// - Receiver 2 drives the bus only while receiver 1 strobe is high.
`timescale 1ns/1ns
`default_nettype none
module avrx_top (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   // Host bus
   input wire logic [15:0] bd_i,
   output logic [15:0] bd_o,
   output logic bd_oe_o,
   input wire logic byte_sel_i,
   input wire logic rx1_read_n_i,
   input wire logic rx2_read_n_i,
   input wire logic options_load_strobe_i,
   // Line detectors, bit c is receiver c+1, and transmitter feedback
   input wire logic [1:0] line_one_i,
   input wire logic [1:0] line_zero_i,
   input wire logic tx_line_out_i,
   input wire logic tx_line_out_n_i,
   // Status and transmitter controls
   output logic rx1_word_ready_n_o,
   output logic rx2_word_ready_n_o,
   output logic tx_parity_invert_o,
   output logic tx_rate_sel_o,
   output logic tx_data_tick_o
);
   // ----------------------------------------
   // Reset and pin synchronisers
   // ----------------------------------------
   logic [1:0] rst_sr_q;
   logic rst_n;
   logic [25:0] meta_q, sync_q;
   logic [2:0] prev_q;

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_sr_q <= 2'h0;
      end else begin
         rst_sr_q <= {rst_sr_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sr_q[1];

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= avrx_pkg::SYNC_RESET;
         sync_q <= avrx_pkg::SYNC_RESET;
         prev_q <= 3'h7;
      end else begin
         meta_q <= {bd_i, byte_sel_i, rx1_read_n_i, rx2_read_n_i, options_load_strobe_i,
                    line_one_i, line_zero_i, tx_line_out_i, tx_line_out_n_i};
         sync_q <= meta_q;
         prev_q <= {sync_q[8], sync_q[7], sync_q[6]};
      end
   end

   logic [15:0] bd_s;
   logic sel_s, rd1_s, rd2_s, cw_s, rd1_end, rd2_end, cw_rise;
   assign bd_s = sync_q[25:10];
   assign sel_s = sync_q[9];
   assign rd1_s = sync_q[8];
   assign rd2_s = sync_q[7];
   assign cw_s = sync_q[6];
   assign cw_rise = cw_s && !prev_q[0];
   assign rd1_end = rd1_s && !prev_q[2];
   // A strobe-2 read only counts if strobe 1 was idle up to its release.
   assign rd2_end = rd2_s && !prev_q[1] && prev_q[2];

   // ----------------------------------------
   // Options word and dividers
   // ----------------------------------------
   function automatic logic [6:0] div_next(input logic [6:0] cnt, input logic slow);
      logic [6:0] lim;
      lim = slow ? avrx_pkg::DIV_SLOW : avrx_pkg::DIV_FAST;
      div_next = (cnt >= lim - 7'h01) ? 7'h00 : cnt + 7'h01;
   endfunction

   logic [9:0] opt_q, opt_d;
   logic [6:0] scnt_q, scnt_d, tcnt_q, tcnt_d;
   logic samp_tick, ttick_q, ttick_d, loop_en;

   always_comb begin
      opt_d = cw_rise ? bd_s[14:5] : opt_q;
      scnt_d = div_next(scnt_q, opt_q[avrx_pkg::OPT_RX_RATE]);
      samp_tick = (scnt_d == 7'h00);
      tcnt_d = div_next(tcnt_q, opt_q[avrx_pkg::OPT_TX_RATE]);
      ttick_d = (tcnt_d == 7'h00);
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         opt_q <= avrx_pkg::OPT_RESET;
         scnt_q <= 7'h00;
         tcnt_q <= 7'h00;
         ttick_q <= 1'b0;
      end else begin
         opt_q <= opt_d;
         scnt_q <= scnt_d;
         tcnt_q <= tcnt_d;
         ttick_q <= ttick_d;
      end
   end

   assign tx_parity_invert_o = opt_q[avrx_pkg::OPT_TX_PAR];
   assign tx_rate_sel_o = opt_q[avrx_pkg::OPT_TX_RATE];
   assign tx_data_tick_o = ttick_q;
   assign loop_en = !opt_q[avrx_pkg::OPT_LOOP_N];

   // ----------------------------------------
   // Receivers
   // ----------------------------------------
   logic [1:0] in_one, in_zero, bad, tbit, tnull, gnull, done, pass;
   avrx_pkg::rx_state_t st_q [2], st_d [2];
   logic [9:0] one_q [2], one_d [2], zero_q [2], zero_d [2], null_q [2], null_d [2];
   logic [3:0] sp_q [2], sp_d [2];
   logic [1:0] gap_q [2], gap_d [2];
   logic [5:0] bcnt_q [2], bcnt_d [2];
   logic [31:0] word_q [2], word_d [2], fw [2];
   logic [1:0] first_q, first_d;

   assign in_one = loop_en ? {2{sync_q[1]}} : sync_q[5:4];
   assign in_zero = loop_en ? {2{sync_q[0]}} : sync_q[3:2];

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         one_d[c] = one_q[c];
         zero_d[c] = zero_q[c];
         null_d[c] = null_q[c];
         st_d[c] = st_q[c];
         sp_d[c] = sp_q[c];
         gap_d[c] = gap_q[c];
         bcnt_d[c] = bcnt_q[c];
         word_d[c] = word_q[c];
         first_d[c] = first_q[c];
         bad[c] = in_one[c] && in_zero[c];
         fw[c] = {~(^word_q[c]), word_q[c][30:0]};
         pass[c] = (c == 0) ?
            (!opt_q[avrx_pkg::OPT_F1_EN] ||
             (word_q[c][8] == opt_q[avrx_pkg::OPT_F1_B9] &&
              word_q[c][9] == opt_q[avrx_pkg::OPT_F1_B10])) :
            (!opt_q[avrx_pkg::OPT_F2_EN] ||
             (word_q[c][8] == opt_q[avrx_pkg::OPT_F2_B9] &&
              word_q[c][9] == opt_q[avrx_pkg::OPT_F2_B10]));
         one_d[c] = samp_tick ? {one_q[c][8:0], in_one[c]} : one_q[c];
         zero_d[c] = samp_tick ? {zero_q[c][8:0], in_zero[c]} : zero_q[c];
         null_d[c] = samp_tick ? {null_q[c][8:0], !in_one[c] && !in_zero[c]} : null_q[c];
         tbit[c] = (one_d[c][2:0] == 3'h7) || (zero_d[c][2:0] == 3'h7);
         tnull[c] = (null_d[c][2:0] == 3'h7);
         gnull[c] = tnull[c] && (null_d[c][9:7] == 3'h7);
         done[c] = 1'b0;
         if (samp_tick) begin
            sp_d[c] = (sp_q[c] == avrx_pkg::SPACE_SAT) ? sp_q[c] : sp_q[c] + 4'h1;
            case (st_q[c])
               avrx_pkg::ST_GAP: begin
                  if (gnull[c]) begin
                     gap_d[c] = gap_q[c] + 2'h1;
                     if (gap_q[c] == avrx_pkg::GAP_NULLS - 2'h1) begin
                        st_d[c] = avrx_pkg::ST_BIT;
                        gap_d[c] = 2'h0;
                        first_d[c] = 1'b1;
                        bcnt_d[c] = 6'h00;
                     end
                  end else begin
                     gap_d[c] = 2'h0;
                  end
               end
               avrx_pkg::ST_BIT: begin
                  if (tbit[c]) begin
                     if (!first_q[c] && (sp_q[c] < avrx_pkg::SPACE_MIN ||
                                         sp_q[c] > avrx_pkg::SPACE_MAX)) begin
                        st_d[c] = avrx_pkg::ST_GAP;
                     end else begin
                        word_d[c][bcnt_q[c][4:0]] = one_d[c][0];
                        bcnt_d[c] = bcnt_q[c] + 6'h01;
                        sp_d[c] = 4'h1;
                        first_d[c] = 1'b0;
                        st_d[c] = avrx_pkg::ST_NULL;
                     end
                  end else if (!first_q[c] && sp_q[c] >= avrx_pkg::SPACE_MAX) begin
                     st_d[c] = avrx_pkg::ST_GAP;
                  end
               end
               avrx_pkg::ST_NULL: begin
                  if (tnull[c]) begin
                     if (bcnt_q[c] == avrx_pkg::WORD_BITS) begin
                        done[c] = pass[c];
                        st_d[c] = avrx_pkg::ST_GAP;
                     end else begin
                        st_d[c] = avrx_pkg::ST_BIT;
                     end
                  end else if (sp_q[c] >= avrx_pkg::SPACE_MAX) begin
                     st_d[c] = avrx_pkg::ST_GAP;
                  end
               end
               default: st_d[c] = avrx_pkg::ST_GAP;
            endcase
            if (bad[c]) begin
               st_d[c] = avrx_pkg::ST_GAP;
               gap_d[c] = 2'h0;
               done[c] = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         for (int c = 0; c < 2; c++) begin
            st_q[c] <= avrx_pkg::ST_GAP;
            one_q[c] <= 10'h000;
            zero_q[c] <= 10'h000;
            null_q[c] <= 10'h000;
            sp_q[c] <= 4'h0;
            gap_q[c] <= 2'h0;
            bcnt_q[c] <= 6'h00;
            word_q[c] <= 32'h00000000;
         end
         first_q <= 2'h3;
      end else begin
         st_q <= st_d;
         one_q <= one_d;
         zero_q <= zero_d;
         null_q <= null_d;
         sp_q <= sp_d;
         gap_q <= gap_d;
         bcnt_q <= bcnt_d;
         word_q <= word_d;
         first_q <= first_d;
      end
   end

   // ----------------------------------------
   // Pending words, buffer and host holding registers
   // ----------------------------------------
   // Reads stall the buffer drain so a word never changes under a strobe.
   avrx_stream_if #(.W(avrx_pkg::FIFO_W)) strm ();
   avrx_fifo #(.W(avrx_pkg::FIFO_W), .DEPTH(avrx_pkg::FIFO_DEPTH)) u_fifo (
      .clk_i(sys_clk_i),
      .rst_n_i(rst_n),
      .s(strm.store)
   );

   logic [1:0] pend_q, pend_d, rdy_q, rdy_d;
   logic [31:0] pw_q [2], pw_d [2], hold_q [2], hold_d [2], rw;
   logic [1:0] half_q [2], half_d [2];
   logic psel, push_fire, pop_fire, pch;
   logic [15:0] bd_d;
   logic oe_d, act1, act2;

   assign psel = !pend_q[0];
   assign strm.push_valid = |pend_q;
   assign strm.push_data = {psel, pw_q[psel]};
   assign push_fire = strm.push_valid && strm.push_ready;
   assign strm.pop_ready = rd1_s && rd2_s;
   assign pop_fire = strm.pop_valid && strm.pop_ready;
   assign pch = strm.pop_data[32];
   assign act1 = !rd1_s;
   assign act2 = rd1_s && !rd2_s;
   assign rw = act1 ? hold_q[0] : hold_q[1];

   always_comb begin
      pend_d = pend_q;
      rdy_d = rdy_q;
      for (int c = 0; c < 2; c++) begin
         pw_d[c] = pw_q[c];
         hold_d[c] = hold_q[c];
         half_d[c] = half_q[c];
      end
      if (push_fire) begin
         pend_d[psel] = 1'b0;
      end
      if (rd1_end) begin
         half_d[0][sel_s] = 1'b1;
      end
      if (rd2_end) begin
         half_d[1][sel_s] = 1'b1;
      end
      for (int c = 0; c < 2; c++) begin
         if (half_d[c] == 2'h3) begin
            rdy_d[c] = 1'b0;
            half_d[c] = 2'h0;
         end
         if (done[c]) begin
            pend_d[c] = 1'b1;
            pw_d[c] = fw[c];
         end
      end
      if (pop_fire) begin
         hold_d[pch] = strm.pop_data[31:0];
         rdy_d[pch] = 1'b1;
         half_d[pch] = 2'h0;
      end
      oe_d = act1 || act2;
      bd_d = bd_o;
      if (oe_d) begin
         bd_d = sel_s ? rw[28:13] :
            {rw[12:8], rw[30], rw[29], rw[31], rw[0], rw[1], rw[2], rw[3],
             rw[4], rw[5], rw[6], rw[7]};
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= 2'h0;
         rdy_q <= 2'h0;
         for (int c = 0; c < 2; c++) begin
            pw_q[c] <= 32'h00000000;
            hold_q[c] <= 32'h00000000;
            half_q[c] <= 2'h0;
         end
         bd_o <= 16'h0000;
         bd_oe_o <= 1'b0;
      end else begin
         pend_q <= pend_d;
         rdy_q <= rdy_d;
         pw_q <= pw_d;
         hold_q <= hold_d;
         half_q <= half_d;
         bd_o <= bd_d;
         bd_oe_o <= oe_d;
      end
   end

   assign rx1_word_ready_n_o = !rdy_q[0];
   assign rx2_word_ready_n_o = !rdy_q[1];

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n);

   property p_opt_load;
      cw_rise |=> opt_q == $past(bd_s[14:5]);
   endproperty
   a_opt_load: assert property (p_opt_load) else $error("options not loaded");

   property p_loop;
      !opt_q[avrx_pkg::OPT_LOOP_N] && samp_tick
         |=> one_q[0][0] == $past(sync_q[1]) && one_q[1][0] == $past(sync_q[1]);
   endproperty
   a_loop: assert property (p_loop) else $error("loopback path wrong");

   property p_filt1;
      push_fire && !psel && opt_q[avrx_pkg::OPT_F1_EN] && !cw_rise
         |-> strm.push_data[8] == opt_q[avrx_pkg::OPT_F1_B9];
   endproperty
   a_filt1: assert property (p_filt1) else $error("receiver 1 filter leak");

   property p_par;
      done[0] |=> pw_q[0][31] == !$past(^word_q[0]);
   endproperty
   a_par: assert property (p_par) else $error("parity bit wrong");

   property p_space;
      samp_tick && st_q[0] == avrx_pkg::ST_BIT && !first_q[0] && tbit[0]
         && sp_q[0] < avrx_pkg::SPACE_MIN |=> st_q[0] == avrx_pkg::ST_GAP;
   endproperty
   a_space: assert property (p_space) else $error("short bit spacing accepted");

   property p_bad;
      samp_tick && bad[1] |=> st_q[1] == avrx_pkg::ST_GAP && gap_q[1] == 2'h0;
   endproperty
   a_bad: assert property (p_bad) else $error("invalid state not rejected");

   property p_gap;
      samp_tick && st_q[0] == avrx_pkg::ST_GAP && gnull[0] && gap_q[0] == 2'h2
         |=> st_q[0] == avrx_pkg::ST_BIT && first_q[0];
   endproperty
   a_gap: assert property (p_gap) else $error("gap count not honoured");

   property p_clear;
      rdy_q[0] && rd1_end && half_q[0][!sel_s] && !(pop_fire && !pch) |=> !rdy_q[0];
   endproperty
   a_clear: assert property (p_clear) else $error("ready not cleared");

   property p_map1;
      !rd1_s && !sel_s |=> bd_oe_o && bd_o[7] == $past(hold_q[0][0])
         && bd_o[8] == $past(hold_q[0][31]) && bd_o[15] == $past(hold_q[0][12]);
   endproperty
   a_map1: assert property (p_map1) else $error("first half mapping wrong");

   property p_rx2;
      rd1_s && !rd2_s && sel_s |=> bd_o == $past(hold_q[1][28:13]);
   endproperty
   a_rx2: assert property (p_rx2) else $error("receiver 2 drive wrong");

   // A load inside the window may change the divisor, so it abandons the attempt.
   property p_rate;
      disable iff (!rst_n || cw_rise)
      samp_tick && !opt_q[avrx_pkg::OPT_RX_RATE] && !cw_rise
         |=> !samp_tick [*8] ##1 !samp_tick ##1 samp_tick;
   endproperty
   a_rate: assert property (p_rate) else $error("sample period wrong");

   c_done: cover property (done[0]);
   c_pop2: cover property (pop_fire && pch);
   c_full: cover property (!strm.push_ready);
endmodule
`default_nettype wire

// >>> pkg/avrx_pkg.sv
// Constants, option bit positions and state codes of the dual receiver.
// Assumes one master clock that feeds every divider.
package avrx_pkg;
   localparam int unsigned OPT_W = 10;
   localparam int unsigned OPT_LSB = 5;
   localparam int unsigned OPT_LOOP_N = 0;
   localparam int unsigned OPT_F1_EN = 1;
   localparam int unsigned OPT_F1_B9 = 2;
   localparam int unsigned OPT_F1_B10 = 3;
   localparam int unsigned OPT_F2_EN = 4;
   localparam int unsigned OPT_F2_B9 = 5;
   localparam int unsigned OPT_F2_B10 = 6;
   localparam int unsigned OPT_TX_PAR = 7;
   localparam int unsigned OPT_TX_RATE = 8;
   localparam int unsigned OPT_RX_RATE = 9;
   localparam logic [9:0] OPT_RESET = 10'h001;
   localparam logic [25:0] SYNC_RESET = 26'h0000180;
   localparam logic [6:0] DIV_FAST = 7'h0A;
   localparam logic [6:0] DIV_SLOW = 7'h50;
   localparam logic [3:0] SPACE_MIN = 4'h8;
   localparam logic [3:0] SPACE_MAX = 4'hC;
   localparam logic [3:0] SPACE_SAT = 4'hD;
   localparam logic [1:0] GAP_NULLS = 2'h3;
   localparam logic [5:0] WORD_BITS = 6'h20;
   localparam int unsigned FIFO_W = 33;
   localparam int unsigned FIFO_DEPTH = 8;
   typedef enum logic [2:0] {
      ST_GAP = 3'h1,
      ST_BIT = 3'h2,
      ST_NULL = 3'h4
   } rx_state_t;
endpackage

// >>> pkg/avrx_stream_if.sv
// Valid/ready word stream between the receivers and the word buffer.
// Assumes both ends share one clock.
`timescale 1ns/1ns
`default_nettype none
interface avrx_stream_if #(parameter int unsigned W = 33);
   logic push_valid;
   logic push_ready;
   logic [W-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [W-1:0] pop_data;
   modport user (output push_valid, push_data, pop_ready,
                 input push_ready, pop_valid, pop_data);
   modport store (input push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

// >>> logic/avrx_fifo.sv
// Word buffer with registered read data and valid/ready on both sides.
// Assumes an active-low reset from the parent, which it applies asynchronously.
`timescale 1ns/1ns
`default_nettype none
module avrx_fifo #(
   parameter int unsigned W = 33,
   parameter int unsigned DEPTH = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Stream
   avrx_stream_if.store s
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0] cnt_q, cnt_d;
   logic [W-1:0] out_q, out_d;
   logic out_v_q, out_v_d;
   logic wr, rd;

   assign s.push_ready = (cnt_q != (AW+1)'(DEPTH));
   assign s.pop_valid = out_v_q;
   assign s.pop_data = out_q;

   always_comb begin
      wr = s.push_valid && s.push_ready;
      rd = (!out_v_q || s.pop_ready) && (cnt_q != '0);
      wp_d = wr ? wp_q + 1'b1 : wp_q;
      rp_d = rd ? rp_q + 1'b1 : rp_q;
      cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
      out_d = rd ? mem[rp_q] : out_q;
      out_v_d = rd ? 1'b1 : (s.pop_ready ? 1'b0 : out_v_q);
   end

   always_ff @(posedge clk_i) begin
      if (wr) begin
         mem[wp_q] <= s.push_data;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         out_q <= '0;
         out_v_q <= 1'b0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
         out_q <= out_d;
         out_v_q <= out_v_d;
      end
   end
endmodule
`default_nettype wire

// >>> verification/arinc_line_model.sv
// Far-side serial transmitter model that drives one receiver's One/Zero detector outputs.
// Assumes the host clock paces it, and that the detector shows Null with both outputs low.
`timescale 1ns/1ns
`default_nettype none
module arinc_line_model (
   // Clock
   input wire logic clk_i,
   // Detector outputs
   output logic one_o,
   output logic zero_o
);
   // Clocks per sample; raise to 80 for the slow rate
   int per = 10;
   initial begin
      one_o = 1'b0;
      zero_o = 1'b0;
   end
   task automatic hold(input logic o, input logic z, input int n);
      one_o = o;
      zero_o = z;
      repeat (n * per) @(posedge clk_i);
      #1;
   endtask
   // ----------------------------------------------------------------
   // Word sender
   // ----------------------------------------------------------------
   // Space is samples from one bit start to the next, split between pulse and Null
   // Bad marks a bit shown as One and Zero
   task automatic send(input logic [31:0] w, input int space, input int bad);
      hold(1'b0, 1'b0, 40);
      for (int i = 0; i < 32; i++) begin
         hold(w[i] | (i == bad), ~w[i] | (i == bad), (space + 1) / 2);
         hold(1'b0, 1'b0, space / 2);
      end
   endtask
endmodule
`default_nettype wire

// >>> verification/test_avrx_top.sv
// Self-checking bench for the dual receiver: options, reception, filtering, host reads.
// Assumes three line models: one per receiver and one on the transmitter feedback.
`timescale 1ns/1ns
`default_nettype none
module test_avrx_top;
   logic sys_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [15:0] bd_i = 16'h0000;
   logic byte_sel_i = 1'b0;
   logic [1:0] rd_n = 2'h3;
   logic cws = 1'b0;
   wire logic [1:0] one;
   wire logic [1:0] zero;
   wire logic [1:0] rdy_n;
   wire logic lo;
   wire logic lz;
   wire logic [15:0] bd_o;
   wire logic bd_oe;
   wire logic tpar;
   wire logic trate;
   wire logic tick;
   int n_fail = 0;
   int total_checks = 0;
   always #10 sys_clk_i = ~sys_clk_i;
   arinc_line_model m1 (.clk_i(sys_clk_i), .one_o(one[0]), .zero_o(zero[0]));
   arinc_line_model m2 (.clk_i(sys_clk_i), .one_o(one[1]), .zero_o(zero[1]));
   arinc_line_model m3 (.clk_i(sys_clk_i), .one_o(lo), .zero_o(lz));
   avrx_top DUT (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .bd_i(bd_i), .bd_o(bd_o),
      .bd_oe_o(bd_oe), .byte_sel_i(byte_sel_i), .rx1_read_n_i(rd_n[0]),
      .rx2_read_n_i(rd_n[1]), .options_load_strobe_i(cws), .line_one_i(one),
      .line_zero_i(zero), .tx_line_out_i(lo), .tx_line_out_n_i(lz),
      .rx1_word_ready_n_o(rdy_n[0]), .rx2_word_ready_n_o(rdy_n[1]),
      .tx_parity_invert_o(tpar), .tx_rate_sel_o(trate), .tx_data_tick_o(tick));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic load(input logic [9:0] v);
      bd_i = {1'b0, v, 5'h00};
      cws = 1'b1;
      cyc(4);
      cws = 1'b0;
      cyc(4);
      bd_i = ~bd_i;
   endtask
   // Strobes is the active-low pair applied together
   task automatic rd(input logic [1:0] strobes, input logic sel, output logic [15:0] d);
      byte_sel_i = sel;
      cyc(1);
      rd_n = strobes;
      cyc(5);
      d = bd_o;
      chk("bus_enable", 16'h0001, {15'h0000, bd_oe});
      rd_n = 2'h3;
      cyc(5);
      chk("bus_release", 16'h0000, {15'h0000, bd_oe});
   endtask
   function automatic logic [15:0] half(input logic [31:0] w, input logic s);
      logic [15:0] h;
      h = {w[12:8], w[30], w[29], ~(^w), 8'h00};
      for (int i = 0; i < 8; i++) h[7 - i] = w[i];
      return s ? w[28:13] : h;
   endfunction
   // Second half first; on receiver 1 the first half is read with both strobes low
   task automatic get_word(input int ch, input logic [31:0] w);
      logic [15:0] d;
      for (int n = 0; n < 200 && rdy_n[ch] !== 1'b0; n++) cyc(1);
      chk("ready_set", 16'h0000, {15'h0000, rdy_n[ch]});
      rd((ch == 0) ? 2'h2 : 2'h1, 1'b1, d);
      chk("second_half", half(w, 1'b1), d);
      chk("ready_held", 16'h0000, {15'h0000, rdy_n[ch]});
      rd((ch == 0) ? 2'h0 : 2'h1, 1'b0, d);
      chk("first_half", half(w, 1'b0), d);
      chk("ready_clear", 16'h0001, {15'h0000, rdy_n[ch]});
   endtask
   task automatic no_word(input int ch);
      cyc(40);
      chk("ready_absent", 16'h0001, {15'h0000, rdy_n[ch]});
   endtask
   task automatic tick_gap(input logic [15:0] e);
      int n;
      for (n = 0; n < 200 && tick !== 1'b1; n++) cyc(1);
      cyc(1);
      for (n = 1; n < 200 && tick !== 1'b1; n++) cyc(1);
      chk("tick_period", e, n[15:0]);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_options();
      chk("parity_reset", 16'h0000, {15'h0000, tpar});
      load(10'h181);
      chk("parity_even", 16'h0001, {15'h0000, tpar});
      chk("rate_slow", 16'h0001, {15'h0000, trate});
      tick_gap(16'h0050);
      load(10'h001);
      chk("parity_odd", 16'h0000, {15'h0000, tpar});
      tick_gap(16'h000A);
   endtask
   task automatic t_basic();
      m1.send(32'h8A5C3E71, 10, -1);
      get_word(0, 32'h8A5C3E71);
      chk("other_ready", 16'h0001, {15'h0000, rdy_n[1]});
   endtask
   task automatic t_filter();
      load(10'h003);
      m1.send(32'h1234A1E5, 10, -1);
      no_word(0);
      load(10'h037);
      fork
         m1.send(32'h1234A1E5, 10, -1);
         m2.send(32'hC0FFE155, 10, -1);
      join
      get_word(0, 32'h1234A1E5);
      get_word(1, 32'hC0FFE155);
      load(10'h001);
   endtask
   task automatic t_errors();
      m1.send(32'h0F0F5AA5, 14, -1);
      no_word(0);
      m1.send(32'h0F0F5AA5, 7, -1);
      no_word(0);
      m2.send(32'h0F0F5AA5, 10, 4);
      no_word(1);
   endtask
   task automatic t_overwrite();
      m2.send(32'h11112222, 10, -1);
      m2.send(32'h7654FEDC, 10, -1);
      get_word(1, 32'h7654FEDC);
   endtask
   task automatic t_loop_slow();
      load(10'h000);
      m3.send(32'h3C5A9601, 10, -1);
      get_word(0, 32'h3C5A9601);
      get_word(1, 32'h3C5A9601);
      load(10'h201);
      m1.per = 80;
      m1.send(32'h4D2B0F88, 10, -1);
      get_word(0, 32'h4D2B0F88);
   endtask
   // ----------------------------------------------------------------
   // Run control
   // ----------------------------------------------------------------
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Longest path is about 60k clocks, almost half of it the slow-rate word
   initial begin
      #(90000 * 20);
      n_fail++;
      final_report();
   end
   initial begin
      cyc(5);
      rstn_i = 1'b1;
      cyc(6);
      t_options();
      t_basic();
      t_filter();
      t_errors();
      t_overwrite();
      t_loop_slow();
      final_report();
   end
endmodule
`default_nettype wire
